// File: include/twis_pkg.sv
// constants, types and field layouts for the timer/watchdog/interrupt/sleep block
// assumes a 100 MHz core clock and an instruction-cycle enable from the core
package twis_pkg;
  localparam int          CLK_MHZ      = 100;
  localparam int          WDT_MS       = 18;
  localparam int          WDT_CYCLES   = WDT_MS * 1000 * CLK_MHZ;
  localparam int          PS_W         = 8;
  // mode register field positions
  localparam int          MODE_PSR_LO  = 0;
  localparam int          MODE_PSC     = 3;
  localparam int          MODE_EDGE    = 4;
  localparam int          MODE_SRC     = 5;
  localparam int          MODE_EXT_EDGE_SELECT  = 6;
  localparam logic [7:0]  MODE_RST     = 8'h3f;
  // flag / mask bit positions
  localparam int          FLG_TMR      = 0;
  localparam int          FLG_PORT     = 1;
  localparam int          FLG_EXT      = 2;
  localparam int          FLG_WDT      = 6;
  localparam logic [7:0]  FLG_USED     = 8'h47;
  // status bits
  localparam int          ST_PD        = 3;
  localparam int          ST_TO        = 4;
  localparam logic [7:0]  ST_RST       = 8'h18;
  // vectors
  localparam logic [9:0]  VEC_IRQ      = 10'h008;
  localparam logic [9:0]  VEC_TRAP     = 10'h001;
  // register addresses of this block
  localparam logic [3:0]  A_TIMER      = 4'h1;
  localparam logic [3:0]  A_STATUS     = 4'h3;
  localparam logic [3:0]  A_ISR        = 4'hf;
  localparam logic [3:0]  A_MODE       = 4'h8;
  localparam logic [3:0]  A_MASK       = 4'h9;
  localparam logic [3:0]  A_CHGEN      = 4'ha;
  localparam logic [3:0]  A_DIR        = 4'hb;
  localparam logic [3:0]  A_SYSCTL     = 4'hc;
  localparam int          SYS_EIS      = 6;

  typedef struct packed {
    logic sleep;
    logic wdtClear;
    logic irqOn;
    logic irqOff;
    logic irqReturn;
    logic trap;
  } twis_op_t;

  typedef struct packed {
    logic       wdtEnable;
    logic       wdtResetSel;
    logic       resetPinIo;
    logic [1:0] oscPinsIo;
  } twis_cfg_t;

  typedef struct packed {
    logic       vecValid;
    logic [9:0] vecAddr;
    logic       wake;
    logic       resetReq;
    logic       sleeping;
    logic       oscStop;
  } twis_ctl_t;
endpackage

// File: verilog/twis_top.sv
// timer, watchdog, shared prescaler, interrupt flags and sleep control
// assumes the core pulses opStrobes for one cycle, and instrTick once per instruction cycle
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
// Functional notes
// - 8-bit timer; internal source adds one per instruction cycle without prescaler.
// - mode bit 5 selects pin edge counting; bit 4 selects edge polarity.
// - watchdog runs on own tick through sleep; timeout resets and clears timeout flag.
// - watchdog period 18 ms, lengthened by prescaler up to 1:128.
// - one prescaler serves watchdog when target bit set, timer otherwise.
// - writing timer clears prescaler when assigned to timer.
// - watchdog clear op clears watchdog and prescaler when assigned to it.
// - global enable set by on op, cleared by off op, set by return.
// - hardware interrupt vectors to 008h; software trap vectors to 001h.
// - flags set by events regardless of mask, except port change flag, which needs its mask bit; software clears them.
// - status register reads flags AND mask.
// - selected edge on external pin sets external flag; mask disables.
// - timer wrap FFh to 00h sets overflow flag; mask disables.
// - change on enabled input pins sets port change flag.
// - external interrupt on pin 0 turns off change detection there.
// - watchdog interrupt mode sets watchdog flag instead of reset.
// - sleep clears powerdown, sets timeout, clears watchdog, stops oscillator.
// - wake on reset pin, watchdog timeout, external or enabled port change interrupt.
// - interrupt wake branches to 008h if global enable set, else continues.
// - mask bit 2 enables external interrupt, bit 6 watchdog interrupt.
// - configuration bit 3 selects watchdog reset when 1, interrupt when 0.
module twis_top #(
  parameter int WDT_TIMEOUT = twis_pkg::WDT_CYCLES
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // core timing and operations
  input  wire logic                 instrTick,
  input  wire logic                 wdtTick,
  input  wire twis_pkg::twis_op_t   opStrobes,
  input  wire twis_pkg::twis_cfg_t  cfgWord,
  input  wire logic                 resetPinReq,
  // register port
  input  wire logic [3:0]           regAddr,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [7:0]           regRdata,
  // pins
  input  wire logic                 timerExtClockPin,
  input  wire logic [7:0]           portIn,
  // control out
  output twis_pkg::twis_ctl_t       ctl,
  output logic                      irqPending,
  output logic      [7:0]           portDir
);
  localparam int WCW = $clog2(WDT_TIMEOUT + 1);

  typedef struct packed {
    logic [7:0]     timer;
    logic [7:0]     presc;
    logic [WCW-1:0] wdt;
    logic [7:0]     mode;
    logic [7:0]     flags;
    logic [7:0]     mask;
    logic [7:0]     chgEn;
    logic [7:0]     dir;
    logic [7:0]     sysctl;
    logic [7:0]     status;
    logic [7:0]     portLast;
    logic           extLast;
    logic           tckLast;
    logic           gie;
    logic           sleeping;
    logic           vecValid;
    logic [9:0]     vecAddr;
    logic           wake;
    logic           resetReq;
    logic [7:0]     rdata;
  } twis_state_t;

  twis_state_t s_q;
  twis_state_t s_d;

  logic       psToWdt;
  logic [7:0] psMask;
  logic       psTap;
  logic       timerSrc;
  logic       tmrInc;
  logic       wdtBase;
  logic       wdtStep;
  logic       wdtExpire;
  logic       extPin;
  logic       extEdge;
  logic       tckEdge;
  logic [7:0] chgLive;
  logic       chgEvt;
  logic       tmrWrap;
  logic [7:0] setFlags;
  logic       irqReq;
  logic [2:0] ratio;

  always_comb begin
    psToWdt  = s_q.mode[twis_pkg::MODE_PSC];
    ratio    = s_q.mode[twis_pkg::MODE_PSR_LO +: 3];
    // timer ratio 1:(2<<r), topping out at 1:256; watchdog 1:(1<<r), topping out at 1:128
    psMask   = psToWdt ? 8'((9'h1 << ratio) - 9'h1) : 8'((9'h2 << ratio) - 9'h1);
    extPin   = portIn[0];
    // edge detection on registered pin copies
    tckEdge  = s_q.mode[twis_pkg::MODE_EDGE] ? (s_q.tckLast & ~timerExtClockPin)
                                              : (~s_q.tckLast & timerExtClockPin);
    extEdge  = s_q.mode[twis_pkg::MODE_EXT_EDGE_SELECT] ? (~s_q.extLast & extPin)
                                                : (s_q.extLast & ~extPin);
    timerSrc = s_q.mode[twis_pkg::MODE_SRC] ? tckEdge : (instrTick & ~s_q.sleeping);
    wdtBase  = wdtTick & cfgWord.wdtEnable;
    psTap    = ((s_q.presc & psMask) == psMask);
    tmrInc   = psToWdt ? timerSrc : (timerSrc & psTap);
    wdtStep  = psToWdt ? (wdtBase & psTap) : wdtBase;
    wdtExpire = wdtStep && (s_q.wdt == WCW'(WDT_TIMEOUT - 1));
    tmrWrap  = tmrInc && (s_q.timer == 8'hff);
    chgLive  = s_q.chgEn & s_q.dir & {2'h3, cfgWord.oscPinsIo, cfgWord.resetPinIo, 3'h7};
    chgLive[0] = chgLive[0] & ~s_q.sysctl[twis_pkg::SYS_EIS];
    chgEvt   = |((portIn ^ s_q.portLast) & chgLive);
    setFlags = '0;
    setFlags[twis_pkg::FLG_TMR]  = tmrWrap;
    setFlags[twis_pkg::FLG_EXT]  = extEdge & s_q.sysctl[twis_pkg::SYS_EIS];
    // port change flag only when its mask is set
    setFlags[twis_pkg::FLG_PORT] = chgEvt & s_q.mask[twis_pkg::FLG_PORT];
    setFlags[twis_pkg::FLG_WDT]  = wdtExpire & ~cfgWord.wdtResetSel;
    irqReq   = |(s_q.flags & s_q.mask);
  end

  always_comb begin
    s_d = s_q;
    s_d.vecValid = 1'b0;
    s_d.wake     = 1'b0;
    s_d.resetReq = 1'b0;
    s_d.tckLast  = timerExtClockPin;
    s_d.extLast  = extPin;
    s_d.rdata    = 8'h00;
    // prescaler advance from whichever source owns it
    if (psToWdt ? wdtBase : timerSrc) begin
      s_d.presc = (psTap) ? 8'h00 : s_q.presc + 8'h01;
    end
    if (tmrInc) begin
      s_d.timer = s_q.timer + 8'h01;
    end
    if (wdtStep) begin
      s_d.wdt = wdtExpire ? '0 : s_q.wdt + WCW'(1);
    end
    if (wdtExpire && cfgWord.wdtResetSel) begin
      s_d.resetReq = 1'b1;
      s_d.status[twis_pkg::ST_TO] = 1'b0;
    end
    // register writes, then hardware sets win over clears
    if (regWrite) begin
      case (regAddr)
        twis_pkg::A_TIMER: begin
          s_d.timer = regWdata;
          if (!psToWdt) begin
            s_d.presc = 8'h00;
          end
        end
        twis_pkg::A_ISR:    s_d.flags  = regWdata & twis_pkg::FLG_USED;
        twis_pkg::A_MODE:   s_d.mode   = regWdata;
        twis_pkg::A_MASK:   s_d.mask   = regWdata & twis_pkg::FLG_USED;
        twis_pkg::A_CHGEN:  s_d.chgEn  = regWdata;
        twis_pkg::A_DIR:    s_d.dir    = regWdata;
        twis_pkg::A_SYSCTL: s_d.sysctl = regWdata;
        default: begin
        end
      endcase
    end
    s_d.flags = s_d.flags | setFlags;
    if (regRead) begin
      case (regAddr)
        twis_pkg::A_TIMER:  s_d.rdata = s_q.timer;
        twis_pkg::A_STATUS: s_d.rdata = s_q.status;
        twis_pkg::A_ISR:    s_d.rdata = s_q.flags & s_q.mask;
        twis_pkg::A_MODE:   s_d.rdata = s_q.mode;
        twis_pkg::A_MASK:   s_d.rdata = s_q.mask;
        twis_pkg::A_CHGEN:  s_d.rdata = s_q.chgEn;
        twis_pkg::A_DIR:    s_d.rdata = s_q.dir;
        twis_pkg::A_SYSCTL: s_d.rdata = s_q.sysctl;
        default:            s_d.rdata = 8'h00;
      endcase
    end
    // port snapshot refreshed by reads, watched lines track continuously
    s_d.portLast = (portIn & chgLive) | (s_q.portLast & ~chgLive);
    if (regRead) begin
      s_d.portLast = portIn;
    end
    if (opStrobes.wdtClear) begin
      s_d.wdt = '0;
      if (psToWdt) begin
        s_d.presc = 8'h00;
      end
      s_d.status[twis_pkg::ST_TO] = 1'b1;
      s_d.status[twis_pkg::ST_PD] = 1'b1;
    end
    if (opStrobes.irqOn) begin
      s_d.gie = 1'b1;
    end
    if (opStrobes.irqOff) begin
      s_d.gie = 1'b0;
    end
    if (opStrobes.irqReturn) begin
      s_d.gie = 1'b1;
    end
    if (opStrobes.trap) begin
      s_d.vecValid = 1'b1;
      s_d.vecAddr  = twis_pkg::VEC_TRAP;
      s_d.gie      = 1'b0;
    end else if (!s_q.sleeping && s_q.gie && irqReq && !opStrobes.irqReturn) begin
      s_d.vecValid = 1'b1;
      s_d.vecAddr  = twis_pkg::VEC_IRQ;
      s_d.gie      = 1'b0;
    end
    if (opStrobes.sleep && !s_q.sleeping) begin
      s_d.sleeping = 1'b1;
      s_d.wdt = '0;
      s_d.status[twis_pkg::ST_PD] = 1'b0;
      s_d.status[twis_pkg::ST_TO] = 1'b1;
    end
    if (s_q.sleeping) begin
      if (resetPinReq || (wdtExpire && cfgWord.wdtResetSel)) begin
        s_d.sleeping = 1'b0;
        s_d.wake     = 1'b1;
      end else if (|(setFlags & s_q.mask)) begin
        s_d.sleeping = 1'b0;
        s_d.wake     = 1'b1;
        if (s_q.gie) begin
          s_d.vecValid = 1'b1;
          s_d.vecAddr  = twis_pkg::VEC_IRQ;
          s_d.gie      = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_q          <= '0;
      s_q.mode     <= twis_pkg::MODE_RST;
      s_q.chgEn    <= 8'hff;
      s_q.dir      <= 8'hff;
      s_q.status   <= twis_pkg::ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    regRdata         = s_q.rdata;
    portDir          = s_q.dir;
    irqPending       = irqReq & s_q.gie;
    ctl.vecValid     = s_q.vecValid;
    ctl.vecAddr      = s_q.vecAddr;
    ctl.wake         = s_q.wake;
    ctl.resetReq     = s_q.resetReq;
    ctl.sleeping     = s_q.sleeping;
    ctl.oscStop      = s_q.sleeping;
  end

  // vectors and global enable
  AST_TRAP_VEC: assert property (@(posedge clock) disable iff (!resetn)
    opStrobes.trap |=> ctl.vecValid && ctl.vecAddr == twis_pkg::VEC_TRAP)
    else $error("trap did not vector to 001h");

  AST_HW_VEC: assert property (@(posedge clock) disable iff (!resetn)
    !s_q.sleeping && s_q.gie && irqReq && !opStrobes.trap && !opStrobes.irqReturn
    |=> ctl.vecValid && ctl.vecAddr == twis_pkg::VEC_IRQ)
    else $error("interrupt did not vector to 008h");

  AST_GIE_ON: assert property (@(posedge clock) disable iff (!resetn)
    (opStrobes.irqOn || opStrobes.irqReturn) && !opStrobes.trap && !opStrobes.irqOff
    && !(irqReq && !s_q.sleeping && s_q.gie && !opStrobes.irqReturn) |=> s_q.gie)
    else $error("global enable not set");

  AST_GIE_OFF: assert property (@(posedge clock) disable iff (!resetn)
    opStrobes.irqOff && !opStrobes.irqReturn |=> !s_q.gie)
    else $error("global enable not cleared");

  // register reads
  AST_ISR_AND: assert property (@(posedge clock) disable iff (!resetn)
    regRead && regAddr == twis_pkg::A_ISR
    |=> regRdata == ($past(s_q.flags) & $past(s_q.mask)))
    else $error("status read not masked");

  AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!resetn)
    !regRead |=> regRdata == 8'h00)
    else $error("read data not idle");

  // timer and prescaler
  AST_WRAP_FLAG: assert property (@(posedge clock) disable iff (!resetn)
    tmrInc && s_q.timer == 8'hff && !(regWrite && regAddr == twis_pkg::A_TIMER)
    |=> s_q.timer == 8'h00 && s_q.flags[twis_pkg::FLG_TMR])
    else $error("wrap did not set overflow flag");

  AST_TMR_STEP: assert property (@(posedge clock) disable iff (!resetn)
    tmrInc && s_q.timer != 8'hff && !(regWrite && regAddr == twis_pkg::A_TIMER)
    |=> s_q.timer == $past(s_q.timer) + 8'h01)
    else $error("timer did not advance by one");

  AST_TMR_STILL: assert property (@(posedge clock) disable iff (!resetn)
    !tmrInc && !(regWrite && regAddr == twis_pkg::A_TIMER) |=> $stable(s_q.timer))
    else $error("timer moved without a count");

  AST_TMR_WR_PS: assert property (@(posedge clock) disable iff (!resetn)
    regWrite && regAddr == twis_pkg::A_TIMER && !psToWdt && !opStrobes.wdtClear
    |=> s_q.presc == 8'h00 && s_q.timer == $past(regWdata))
    else $error("timer write did not clear prescaler");

  AST_PS_WDT_OWN: assert property (@(posedge clock) disable iff (!resetn)
    psToWdt && !wdtBase && !opStrobes.wdtClear |=> $stable(s_q.presc))
    else $error("prescaler moved by timer while owned by watchdog");

  AST_PS_CLR: assert property (@(posedge clock) disable iff (!resetn)
    opStrobes.wdtClear && psToWdt |=> s_q.presc == 8'h00)
    else $error("watchdog clear left prescaler");

  // flags
  AST_FLAG_WR: assert property (@(posedge clock) disable iff (!resetn)
    regWrite && regAddr == twis_pkg::A_ISR
    |=> s_q.flags == (($past(regWdata) & twis_pkg::FLG_USED) | $past(setFlags)))
    else $error("flag write or set wrong");

  AST_EXT_FLAG: assert property (@(posedge clock) disable iff (!resetn)
    extEdge && s_q.sysctl[twis_pkg::SYS_EIS] |=> s_q.flags[twis_pkg::FLG_EXT])
    else $error("external edge did not set flag");

  AST_PORT_FLAG: assert property (@(posedge clock) disable iff (!resetn)
    chgEvt && s_q.mask[twis_pkg::FLG_PORT] |=> s_q.flags[twis_pkg::FLG_PORT])
    else $error("port change did not set flag");

  AST_PIN0_OFF: assert property (@(posedge clock) disable iff (!resetn)
    s_q.sysctl[twis_pkg::SYS_EIS] |-> !chgLive[0])
    else $error("pin 0 change detect still live");

  // watchdog
  AST_WDT_STEP: assert property (@(posedge clock) disable iff (!resetn)
    wdtStep && !wdtExpire && !opStrobes.wdtClear && !(opStrobes.sleep && !s_q.sleeping)
    |=> s_q.wdt == $past(s_q.wdt) + WCW'(1))
    else $error("watchdog did not advance");

  AST_WDT_CLR: assert property (@(posedge clock) disable iff (!resetn)
    opStrobes.wdtClear |=> s_q.wdt == '0)
    else $error("watchdog clear failed");

  AST_WDT_RESET: assert property (@(posedge clock) disable iff (!resetn)
    wdtExpire && cfgWord.wdtResetSel && !opStrobes.wdtClear
    |=> ctl.resetReq && !s_q.status[twis_pkg::ST_TO])
    else $error("watchdog timeout did not reset");

  AST_WDT_IRQ: assert property (@(posedge clock) disable iff (!resetn)
    wdtExpire && !cfgWord.wdtResetSel |=> s_q.flags[twis_pkg::FLG_WDT] && !ctl.resetReq)
    else $error("watchdog interrupt mode wrong");

  // sleep and wake
  AST_SLEEP_BITS: assert property (@(posedge clock) disable iff (!resetn)
    opStrobes.sleep && !s_q.sleeping && !opStrobes.wdtClear
    |=> ctl.sleeping && !s_q.status[twis_pkg::ST_PD] && s_q.status[twis_pkg::ST_TO])
    else $error("sleep status wrong");

  AST_SLEEP_WDT: assert property (@(posedge clock) disable iff (!resetn)
    opStrobes.sleep && !s_q.sleeping |=> s_q.wdt == '0)
    else $error("sleep did not clear watchdog");

  AST_WAKE_PIN: assert property (@(posedge clock) disable iff (!resetn)
    s_q.sleeping && resetPinReq |=> ctl.wake && !ctl.sleeping)
    else $error("reset pin did not wake");

  AST_SLEEP_STAY: assert property (@(posedge clock) disable iff (!resetn)
    s_q.sleeping && !resetPinReq && !(wdtExpire && cfgWord.wdtResetSel)
    && !(|(setFlags & s_q.mask)) |=> ctl.sleeping)
    else $error("left sleep without cause");

  AST_WAKE_VEC: assert property (@(posedge clock) disable iff (!resetn)
    s_q.sleeping && !resetPinReq && !(wdtExpire && cfgWord.wdtResetSel)
    && (|(setFlags & s_q.mask)) && s_q.gie
    |=> ctl.vecValid && ctl.vecAddr == twis_pkg::VEC_IRQ)
    else $error("wake did not vector to 008h");

  AST_WAKE_NOVEC: assert property (@(posedge clock) disable iff (!resetn)
    s_q.sleeping && !s_q.gie && !opStrobes.trap |=> !ctl.vecValid)
    else $error("wake vectored with enable off");
endmodule

// File: verif/twis_core_model.sv
// core-side model: instruction tick bursts and a watchdog tick train
// assumes one clock; the bench asks for bursts and gates the watchdog ticks
`timescale 1ns/10ps
module twis_core_model (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       resetn,
  // bench commands
  input  wire logic       start,
  input  wire logic [7:0] nTicks,
  input  wire logic       wdtRun,
  // ticks to the block
  output logic            instrTick,
  output logic            wdtTick,
  output logic            busy
);
  logic [8:0] left_q;
  logic [1:0] div_q;
  assign busy = left_q != 9'h000;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      left_q    <= 9'h000;
      div_q     <= 2'h0;
      instrTick <= 1'b0;
      wdtTick   <= 1'b0;
    end else begin
      // n pulses, one every other cycle
      instrTick <= busy && !left_q[0];
      left_q    <= start ? {nTicks, 1'b0} : left_q - {8'h00, busy};
      // watchdog oscillator stands still unless running
      div_q     <= wdtRun ? div_q + 2'h1 : 2'h0;
      wdtTick   <= wdtRun && div_q == 2'h3;
    end
  end
endmodule

// File: verif/tb_twis_top.sv
// self-checking bench for twis_top: register tasks, op pulses, tick bursts
// assumes twis_core_model for ticks; watchdog count shortened to 20 ticks
`timescale 1ns/10ps
module tb_twis_top;
  logic                clock, resetn, start, wdtRun, instrTick, wdtTick, busy;
  logic                resetPinReq, regWrite, regRead, extPin, irqPending;
  logic                wk, vc, rr;
  logic [3:0]          regAddr;
  logic [7:0]          nTicks, regWdata, regRdata, portIn, portDir;
  logic [9:0]          va;
  twis_pkg::twis_op_t  ops;
  twis_pkg::twis_cfg_t cfg;
  twis_pkg::twis_ctl_t ctl;
  int                  n_fail;
  int                  check_count;

  twis_core_model model (.clock(clock), .resetn(resetn), .start(start), .nTicks(nTicks),
    .wdtRun(wdtRun), .instrTick(instrTick), .wdtTick(wdtTick), .busy(busy));
  twis_top #(.WDT_TIMEOUT(20)) dut (.clock(clock), .resetn(resetn), .instrTick(instrTick),
    .wdtTick(wdtTick), .opStrobes(ops), .cfgWord(cfg), .resetPinReq(resetPinReq),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .timerExtClockPin(extPin), .portIn(portIn), .ctl(ctl),
    .irqPending(irqPending), .portDir(portDir));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    regAddr  <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    chk(regRdata & m, e, "register read");
  endtask
  task automatic op(input logic [5:0] o);
    @(posedge clock);
    ops <= o;
    @(posedge clock);
    ops <= '0;
  endtask
  task automatic ticks(input logic [7:0] n);
    @(posedge clock);
    start  <= 1'b1;
    nTicks <= n;
    @(posedge clock);
    start <= 1'b0;
    repeat (2 * n + 4) @(posedge clock);
  endtask
  // collects the control pulses seen over n cycles
  task automatic watch(input int n);
    wk = 1'b0;
    vc = 1'b0;
    rr = 1'b0;
    repeat (n) begin
      #1;
      if (ctl.wake === 1'b1) wk = 1'b1;
      if (ctl.resetReq === 1'b1) rr = 1'b1;
      if (ctl.vecValid === 1'b1) begin
        vc = 1'b1;
        va = ctl.vecAddr;
      end
      @(posedge clock);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    {resetn, start, wdtRun, resetPinReq, regWrite, regRead, extPin} = '0;
    {nTicks, regWdata, portIn, regAddr} = '0;
    ops = '0;
    cfg = 5'h0c;
    n_fail = 0;
    check_count = 0;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    chk(portDir, 8'hff, "direction reset");
    rc(twis_pkg::A_MODE, 8'hff, 8'h3f);
    rc(twis_pkg::A_STATUS, 8'h18, 8'h18);
    rc(4'h0, 8'hff, 8'h00);
    $display("test reset done");
    wr(twis_pkg::A_MODE, 8'h08);
    wr(twis_pkg::A_TIMER, 8'hfd);
    ticks(5);
    rc(twis_pkg::A_TIMER, 8'hff, 8'h02);
    rc(twis_pkg::A_ISR, 8'hff, 8'h00);
    wr(twis_pkg::A_MASK, 8'h01);
    rc(twis_pkg::A_ISR, 8'hff, 8'h01);
    chk({7'h00, irqPending}, 8'h00, "no global enable");
    wr(twis_pkg::A_ISR, 8'h00);
    op(6'h10);
    wr(twis_pkg::A_MODE, 8'h00);
    wr(twis_pkg::A_TIMER, 8'h00);
    ticks(1);
    wr(twis_pkg::A_TIMER, 8'h00);
    ticks(1);
    rc(twis_pkg::A_TIMER, 8'hff, 8'h00);
    ticks(1);
    rc(twis_pkg::A_TIMER, 8'hff, 8'h01);
    wr(twis_pkg::A_TIMER, 8'h00);
    wr(twis_pkg::A_MODE, 8'h08);
    op(6'h10);
    $display("test timer done");
    for (int e = 0; e < 2; e++) begin
      wr(twis_pkg::A_MODE, {3'h1, e[0], 4'h8});
      wr(twis_pkg::A_TIMER, 8'h00);
      extPin <= 1'b1;
      repeat (6) @(posedge clock);
      rc(twis_pkg::A_TIMER, 8'hff, {7'h00, !e[0]});
      extPin <= 1'b0;
      repeat (6) @(posedge clock);
      rc(twis_pkg::A_TIMER, 8'hff, 8'h01);
    end
    $display("test pin clock done");
    wr(twis_pkg::A_SYSCTL, 8'h40);
    wr(twis_pkg::A_MODE, 8'h48);
    portIn[0] <= 1'b1;
    wr(twis_pkg::A_MASK, 8'h04);
    rc(twis_pkg::A_ISR, 8'hff, 8'h04);
    op(6'h08);
    watch(10);
    chk({vc, va[6:0]}, 8'h88, "hardware vector");
    wr(twis_pkg::A_ISR, 8'h00);
    op(6'h01);
    watch(10);
    chk({vc, va[6:0]}, 8'h81, "trap vector");
    wr(twis_pkg::A_MASK, 8'h06);
    rc(twis_pkg::A_MODE, 8'h00, 8'h00);
    portIn[0] <= 1'b0;
    rc(twis_pkg::A_ISR, 8'hff, 8'h00);
    portIn[6] <= 1'b1;
    repeat (4) @(posedge clock);
    rc(twis_pkg::A_ISR, 8'hff, 8'h02);
    op(6'h02);
    watch(10);
    chk({vc, va[6:0]}, 8'h88, "return sets enable");
    wr(twis_pkg::A_ISR, 8'h00);
    wr(twis_pkg::A_DIR, 8'h7f);
    portIn[7] <= 1'b1;
    rc(twis_pkg::A_ISR, 8'hff, 8'h00);
    $display("test interrupts done");
    wr(twis_pkg::A_MASK, 8'h00);
    op(6'h20);
    #1;
    chk({6'h00, ctl.sleeping, ctl.oscStop}, 8'h03, "asleep");
    rc(twis_pkg::A_STATUS, 8'h18, 8'h10);
    @(posedge clock);
    resetPinReq <= 1'b1;
    @(posedge clock);
    resetPinReq <= 1'b0;
    watch(10);
    chk({7'h00, wk}, 8'h01, "reset pin wake");
    wr(twis_pkg::A_MASK, 8'h04);
    for (int g = 0; g < 2; g++) begin
      op(g ? 6'h08 : 6'h04);
      op(6'h20);
      portIn[0] <= 1'b1;
      watch(20);
      chk({wk, vc, va[5:0]}, g ? 8'hc8 : {2'b10, va[5:0]}, "interrupt wake");
      portIn[0] <= 1'b0;
      wr(twis_pkg::A_ISR, 8'h00);
    end
    $display("test sleep done");
    wr(twis_pkg::A_MASK, 8'h40);
    cfg <= 5'h14;
    wr(twis_pkg::A_MODE, 8'h09);
    op(6'h10);
    wdtRun <= 1'b1;
    repeat (4) begin
      repeat (120) @(posedge clock);
      op(6'h10);
    end
    rc(twis_pkg::A_ISR, 8'hff, 8'h00);
    repeat (220) @(posedge clock);
    rc(twis_pkg::A_ISR, 8'hff, 8'h40);
    cfg <= 5'h1c;
    wr(twis_pkg::A_ISR, 8'h00);
    op(6'h10);
    watch(250);
    chk({7'h00, rr}, 8'h01, "watchdog reset");
    rc(twis_pkg::A_STATUS, 8'h10, 8'h00);
    wdtRun <= 1'b0;
    $display("test watchdog done");
    tally_and_finish();
  end
endmodule
